// File: core/llc_pkg.sv
// Purpose: Shared constants and carriers for the line loopback control block
// Assumes: One channel per instance except the monitor mux, 50 MHz aclk
// Notes: Register word offsets are byte addresses on AXI4-Lite
package llc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] LOOP_OFFS = 8'h00;
    localparam logic [7:0] PD_OFFS = 8'h04;
    localparam logic [7:0] STAT_OFFS = 8'h08;
    localparam logic [7:0] MON_OFFS = 8'h0c;
    localparam logic [7:0] RX_CONFIG_REG_ZERO_OFFS = 8'h10;
    localparam int ADDR_W = 8;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ANALOG_BIT = 0;
    localparam int REMOTE_BIT = 1;
    localparam int DIGITAL_BIT = 2;
    localparam int AUTO_BIT = 3;
    localparam int PD_SIDE_BIT = 3;
    localparam int AUTO_ACT_BIT = 7;
    localparam int MON_W = 6;
    localparam int TERM_W = 3;
    localparam logic [2:0] TERM_EXTERNAL = 3'h7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint HOLD_MS = 5100;
    localparam longint CLK_HZ = 50000000;
    localparam longint HOLD_CYC = (HOLD_MS * CLK_HZ) / 1000 + 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Auto loop sequencer
    typedef enum logic [2:0] {
        AL_IDLE = 3'b001,
        AL_ARM = 3'b010,
        AL_LOOP = 3'b100
    } llc_al_state_t;

    // Path priority selection for each direction
    typedef enum logic [1:0] {
        SRC_NORMAL = 2'h0,
        SRC_LOOPED = 2'h1,
        SRC_PATTERN = 2'h2,
        SRC_AIS = 2'h3
    } llc_src_t;

    // Steering outputs toward the datapath
    typedef struct packed {
        logic analog_loop;
        logic remote_loop;
        logic digital_loop;
        llc_src_t rx_src;
        llc_src_t tx_src;
        logic rx_ais_inhibit;
        logic tx_ais_inhibit;
        logic tx_pattern_inhibit;
        logic rx_det_on_looped;
        logic tx_det_on_system;
        logic los_on_line;
        logic ignore_tx_clock;
    } llc_steer_t;
endpackage

// File: core/llc_line_loopback_control.sv
// Purpose: Per-channel loopback selection, diagnostic priority and channel 0 monitor
// Assumes: In-band code detect flags arrive synchronous to aclk
// Notes: Registers on AXI4-Lite; answers one cycle after both halves taken
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Analog loop bit loops the channel's line transmit signal back to its receiver.
// - Analog loop keeps transmitting, received line data replaced by looped transmit data.
// - Analog loop forces remote and digital loopback off.
// - Analog loop: receive pattern beats looped data; AIS generation off both ways.
// - Remote loop on when manual bit or automatic remote is active.
// - Receive-side detection plus auto bit: activate code over 5.1 s enters, deactivate leaves.
// - Clearing auto bit ends automatic loop; status bit shows it active.
// - Remote loop sends receive data to shaper, still to system, ignores system tx.
// - Transmit-side detectors keep watching system data in remote loop.
// - Remote: rx pattern beats AIS, tx pattern beats looped, tx AIS off.
// - Digital loop on when manual bit or automatic digital is active.
// - Transmit-side detection plus auto bit: codes over 5.1 s enter or leave.
// - Digital loop feeds transmit data to decoder; LOS and AIS watch line.
// - Digital: rx pattern over looped, tx pattern over looped over AIS, rx AIS off.
// - Dual loop is manual remote plus manual or auto digital; no auto remote then.
// - Dual loop sends nothing outward; rx detectors watch looped data, LOS the line.
// - Both manual: rx pattern over digital loop, tx remote loop over pattern, no AIS.
// - Manual remote plus auto digital: rx pattern over loop; no AIS, no tx pattern.
// - Six-bit monitor select routes another channel into channel 0 when nonzero.
// - Monitoring forces channel 0 external termination; its recovery watches monitored signal.
// - Monitoring channel 0 may take remote loopback to retransmit monitored signal.
module llc_line_loopback_control #(
    parameter int CHANNELS = 16,
    parameter int IS_CHAN0 = 1,
    parameter longint HOLD_CYCLES = llc_pkg::HOLD_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [llc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [llc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // In-band code detector flags
    input wire logic inband_loop_code_activate,
    input wire logic inband_loop_code_deactivate,
    // Channel 0 monitor sources, one per channel
    input wire logic [2*CHANNELS-1:0] mon_rx_pair,
    input wire logic [2*CHANNELS-1:0] mon_tx_pair,
    input wire logic [1:0] line_rx_pair,
    // Steering and monitor outputs
    output llc_pkg::llc_steer_t steer,
    output logic [1:0] chan0_rx_input,
    output logic [llc_pkg::TERM_W-1:0] rx_termination,
    output logic monitor_active
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic analog_loop_en_r, remote_loop_en_r, digital_loop_en_r, auto_loop_en_r;
    logic pattern_detect_side_r;
    logic [llc_pkg::MON_W-1:0] monitor_select_r;
    logic [llc_pkg::TERM_W-1:0] rx_term_r;
    llc_pkg::llc_al_state_t al_state_r, al_state_nxt;
    logic [39:0] hold_cnt_r;
    logic auto_loop_active;
    logic auto_remote, auto_digital, remote_on, digital_on;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_held_r, w_held_r;
    logic [llc_pkg::ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;

    function automatic logic mapped(input logic [llc_pkg::ADDR_W-1:0] a);
        mapped = (a == llc_pkg::LOOP_OFFS) || (a == llc_pkg::PD_OFFS) ||
                 (a == llc_pkg::STAT_OFFS) || (a == llc_pkg::MON_OFFS) ||
                 (a == llc_pkg::RX_CONFIG_REG_ZERO_OFFS);
    endfunction

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= llc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_r) ? llc_pkg::RESP_OKAY : llc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control bits live in byte lane 0, so only that strobe writes them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_loop_en_r <= 1'b0;
            remote_loop_en_r <= 1'b0;
            digital_loop_en_r <= 1'b0;
            auto_loop_en_r <= 1'b0;
            pattern_detect_side_r <= 1'b0;
            monitor_select_r <= '0;
            rx_term_r <= '0;
        end else if (do_write && wstrb_r[0]) begin
            unique case (awaddr_r)
                llc_pkg::LOOP_OFFS: begin
                    analog_loop_en_r <= wdata_r[llc_pkg::ANALOG_BIT];
                    remote_loop_en_r <= wdata_r[llc_pkg::REMOTE_BIT];
                    digital_loop_en_r <= wdata_r[llc_pkg::DIGITAL_BIT];
                    auto_loop_en_r <= wdata_r[llc_pkg::AUTO_BIT];
                end
                // Side changes are the AXI master's duty to avoid while looped
                llc_pkg::PD_OFFS: pattern_detect_side_r <= wdata_r[llc_pkg::PD_SIDE_BIT];
                llc_pkg::MON_OFFS: begin
                    if (IS_CHAN0 != 0) begin
                        monitor_select_r <= wdata_r[llc_pkg::MON_W-1:0];
                    end
                end
                llc_pkg::RX_CONFIG_REG_ZERO_OFFS: rx_term_r <= wdata_r[llc_pkg::TERM_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= llc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? llc_pkg::RESP_OKAY : llc_pkg::RESP_SLVERR;
                s_axi_rdata <= '0;
                unique case (s_axi_araddr)
                    llc_pkg::LOOP_OFFS: begin
                        s_axi_rdata[llc_pkg::ANALOG_BIT] <= analog_loop_en_r;
                        s_axi_rdata[llc_pkg::REMOTE_BIT] <= remote_loop_en_r;
                        s_axi_rdata[llc_pkg::DIGITAL_BIT] <= digital_loop_en_r;
                        s_axi_rdata[llc_pkg::AUTO_BIT] <= auto_loop_en_r;
                    end
                    llc_pkg::PD_OFFS: s_axi_rdata[llc_pkg::PD_SIDE_BIT] <= pattern_detect_side_r;
                    llc_pkg::STAT_OFFS: s_axi_rdata[llc_pkg::AUTO_ACT_BIT] <= auto_loop_active;
                    llc_pkg::MON_OFFS: s_axi_rdata[llc_pkg::MON_W-1:0] <= monitor_select_r;
                    llc_pkg::RX_CONFIG_REG_ZERO_OFFS: s_axi_rdata[llc_pkg::TERM_W-1:0] <= rx_term_r;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Automatic loop sequencer, one per channel
    // ------------------------------------------------------------
    // A code must persist for the whole hold time; any gap restarts the count
    logic code_seen, hold_done;
    assign code_seen = (al_state_r == llc_pkg::AL_LOOP) ? inband_loop_code_deactivate
                                                        : inband_loop_code_activate;
    assign hold_done = (hold_cnt_r >= 40'(HOLD_CYCLES - 1));

    always_comb begin
        al_state_nxt = al_state_r;
        unique case (al_state_r)
            llc_pkg::AL_IDLE: if (code_seen) al_state_nxt = llc_pkg::AL_ARM;
            llc_pkg::AL_ARM: begin
                if (!code_seen) al_state_nxt = llc_pkg::AL_IDLE;
                else if (hold_done) al_state_nxt = llc_pkg::AL_LOOP;
            end
            llc_pkg::AL_LOOP: if (code_seen && hold_done) al_state_nxt = llc_pkg::AL_IDLE;
            default: al_state_nxt = llc_pkg::AL_IDLE;
        endcase
        if (!auto_loop_en_r) al_state_nxt = llc_pkg::AL_IDLE;
        // Detector sits inside the digital loop, so no automatic remote is possible
        if (!pattern_detect_side_r && digital_loop_en_r) begin
            al_state_nxt = llc_pkg::AL_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            al_state_r <= llc_pkg::AL_IDLE;
            hold_cnt_r <= '0;
        end else begin
            al_state_r <= al_state_nxt;
            if (al_state_nxt != al_state_r || !code_seen) hold_cnt_r <= '0;
            else if (!hold_done) hold_cnt_r <= hold_cnt_r + 40'h1;
        end
    end

    // ------------------------------------------------------------
    // Loop selection and priority
    // ------------------------------------------------------------
    assign auto_loop_active = (al_state_r == llc_pkg::AL_LOOP);
    // Auto remote needs the detector outside the digital loop
    assign auto_remote = auto_loop_active && !pattern_detect_side_r &&
                         !digital_loop_en_r;
    assign auto_digital = auto_loop_active && pattern_detect_side_r;
    assign remote_on = !analog_loop_en_r &&
                       (remote_loop_en_r || auto_remote);
    assign digital_on = !analog_loop_en_r &&
                        (digital_loop_en_r || auto_digital);

    always_comb begin
        steer = '0;
        steer.analog_loop = analog_loop_en_r;
        steer.remote_loop = remote_on;
        steer.digital_loop = digital_on;
        steer.rx_src = llc_pkg::SRC_PATTERN;
        steer.tx_src = llc_pkg::SRC_PATTERN;
        steer.los_on_line = 1'b1;
        steer.tx_det_on_system = 1'b1;
        if (analog_loop_en_r) begin
            steer.tx_src = llc_pkg::SRC_PATTERN;
            steer.rx_src = llc_pkg::SRC_PATTERN;
            steer.rx_ais_inhibit = 1'b1;
            steer.tx_ais_inhibit = 1'b1;
        end else if (remote_on && digital_on) begin
            steer.rx_det_on_looped = 1'b1;
            steer.ignore_tx_clock = 1'b1;
            steer.rx_ais_inhibit = 1'b1;
            steer.tx_ais_inhibit = 1'b1;
            steer.tx_src = llc_pkg::SRC_LOOPED;
            steer.tx_pattern_inhibit = auto_digital && !digital_loop_en_r;
        end else if (remote_on) begin
            steer.ignore_tx_clock = 1'b1;
            steer.tx_src = llc_pkg::SRC_PATTERN;
            steer.rx_src = llc_pkg::SRC_PATTERN;
            steer.tx_ais_inhibit = 1'b1;
        end else if (digital_on) begin
            steer.rx_det_on_looped = 1'b1;
            steer.rx_src = llc_pkg::SRC_PATTERN;
            steer.tx_src = llc_pkg::SRC_PATTERN;
            steer.rx_ais_inhibit = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Channel 0 monitoring
    // ------------------------------------------------------------
    // Codes 1..15 pick a receiver, 16..31 a transmitter; taps only, never drives
    logic [4:0] mon_idx;
    always_comb begin
        mon_idx = monitor_select_r[4:0];
        monitor_active = (IS_CHAN0 != 0) && (monitor_select_r != '0);
        chan0_rx_input = line_rx_pair;
        if (monitor_active && (32'(mon_idx[3:0]) < CHANNELS)) begin
            if (mon_idx[4]) chan0_rx_input = mon_tx_pair[2*mon_idx[3:0] +: 2];
            else chan0_rx_input = mon_rx_pair[2*mon_idx[3:0] +: 2];
        end
        rx_termination = monitor_active ? llc_pkg::TERM_EXTERNAL : rx_term_r;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_analog_kills;
        @(posedge aclk) disable iff (!aresetn)
        analog_loop_en_r |-> !steer.remote_loop && !steer.digital_loop;
    endproperty
    a_analog_kills: assert property (p_analog_kills) else $error("loop beside analog");

    property p_auto_off;
        @(posedge aclk) disable iff (!aresetn)
        $fell(auto_loop_en_r) |=> !auto_loop_active;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("auto loop kept");

    property p_remote_manual;
        @(posedge aclk) disable iff (!aresetn)
        remote_loop_en_r && !analog_loop_en_r |-> steer.remote_loop;
    endproperty
    a_remote_manual: assert property (p_remote_manual) else $error("remote missing");

    property p_digital_manual;
        @(posedge aclk) disable iff (!aresetn)
        digital_loop_en_r && !analog_loop_en_r |-> steer.digital_loop;
    endproperty
    a_digital_manual: assert property (p_digital_manual) else $error("digital missing");

    property p_enter_after_hold;
        @(posedge aclk) disable iff (!aresetn)
        $rose(auto_loop_active) |-> $past(inband_loop_code_activate) && $past(hold_done);
    endproperty
    a_enter_after_hold: assert property (p_enter_after_hold) else $error("early entry");

    property p_no_auto_remote;
        @(posedge aclk) disable iff (!aresetn)
        digital_loop_en_r && !remote_loop_en_r && !analog_loop_en_r
            |-> steer.remote_loop == 1'b0;
    endproperty
    a_no_auto_remote: assert property (p_no_auto_remote) else $error("auto remote in dig");

    property p_dual_tx;
        @(posedge aclk) disable iff (!aresetn)
        steer.remote_loop && steer.digital_loop
            |-> steer.tx_src == llc_pkg::SRC_LOOPED && steer.rx_ais_inhibit && steer.tx_ais_inhibit;
    endproperty
    a_dual_tx: assert property (p_dual_tx) else $error("dual priority wrong");

    property p_mon_term;
        @(posedge aclk) disable iff (!aresetn)
        monitor_active |-> rx_termination == llc_pkg::TERM_EXTERNAL;
    endproperty
    a_mon_term: assert property (p_mon_term) else $error("termination not external");

    property p_remote_ais;
        @(posedge aclk) disable iff (!aresetn)
        steer.remote_loop && !steer.digital_loop |-> steer.tx_ais_inhibit && !steer.rx_ais_inhibit;
    endproperty
    a_remote_ais: assert property (p_remote_ais) else $error("remote AIS wrong");

    property p_analog_prio;
        @(posedge aclk) disable iff (!aresetn)
        analog_loop_en_r |-> steer.rx_src == llc_pkg::SRC_PATTERN && steer.rx_ais_inhibit &&
            steer.tx_ais_inhibit;
    endproperty
    a_analog_prio: assert property (p_analog_prio) else $error("analog priority wrong");

    property p_digital_prio;
        @(posedge aclk) disable iff (!aresetn)
        steer.digital_loop && !steer.remote_loop
            |-> steer.rx_ais_inhibit && !steer.tx_ais_inhibit && steer.rx_det_on_looped;
    endproperty
    a_digital_prio: assert property (p_digital_prio) else $error("digital priority wrong");

    property p_dual_auto;
        @(posedge aclk) disable iff (!aresetn)
        steer.remote_loop && steer.digital_loop && !digital_loop_en_r
            |-> steer.tx_pattern_inhibit && steer.rx_ais_inhibit && steer.tx_ais_inhibit;
    endproperty
    a_dual_auto: assert property (p_dual_auto) else $error("dual auto priority wrong");

    property p_auto_gone;
        @(posedge aclk) disable iff (!aresetn)
        !pattern_detect_side_r && digital_loop_en_r |=> !auto_loop_active;
    endproperty
    a_auto_gone: assert property (p_auto_gone) else $error("auto remote in digital");

    property p_mon_idle;
        @(posedge aclk) disable iff (!aresetn)
        !monitor_active |-> chan0_rx_input == line_rx_pair && rx_termination == rx_term_r;
    endproperty
    a_mon_idle: assert property (p_mon_idle) else $error("monitor path leaks");

endmodule // llc_line_loopback_control
`default_nettype wire

// File: testbench/llc_far_side.sv
// Purpose: Far side stand-in: in-band code detector flags and line taps
// Assumes: Codes are levels held by the bench, one aclk domain
// Notes: Taps change every cycle so a stale mux select shows up
`timescale 1ns/10ps
`default_nettype none
module llc_far_side (
    // Clock and control
    input wire logic aclk,
    input wire logic [1:0] code_mode,
    // Toward the block
    output logic act,
    output logic deact,
    output logic [31:0] rx_taps,
    output logic [31:0] tx_taps,
    output logic [1:0] line_pair
);
    logic [31:0] cnt = 32'h0;
    always_ff @(posedge aclk) begin
        cnt <= cnt + 32'h9e37;
    end
    assign act = (code_mode == 2'h1);
    assign deact = (code_mode == 2'h2);
    assign rx_taps = cnt ^ 32'h5a5aa5a5;
    assign tx_taps = ~cnt;
    assign line_pair = cnt[1:0];
endmodule // llc_far_side
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the loopback control block
// Assumes: Hold count shortened to 20 cycles
// Notes: Handshakes sampled at the falling edge, driven after the rising edge
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int HOLD = 20;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, mode = 2'h0, lp;
    logic [31:0] rdata, rxt, txt;
    logic act, deact, mact;
    llc_pkg::llc_steer_t steer;
    logic [1:0] c0_in;
    logic [2:0] term;
    int errors = 0, checks = 0;
    llc_far_side i_llc_far_side (.aclk(aclk), .code_mode(mode), .act(act), .deact(deact),
        .rx_taps(rxt), .tx_taps(txt), .line_pair(lp));
    llc_line_loopback_control #(.CHANNELS(16), .IS_CHAN0(1), .HOLD_CYCLES(HOLD))
        i_llc_line_loopback_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .inband_loop_code_activate(act), .inband_loop_code_deactivate(deact),
        .mon_rx_pair(rxt), .mon_tx_pair(txt), .line_rx_pair(lp), .steer(steer),
        .chan0_rx_input(c0_in), .rx_termination(term), .monitor_active(mact));
    initial begin
        forever #10 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) cmp_resp(bresp, er);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            n++;
            if (n > 50) begin
                errors++;
                test_done();
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            if (tr) cmp_data(rdata, ed);
            if (tr) cmp_resp(rresp, er);
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            n++;
            if (n > 50) begin
                errors++;
                test_done();
            end
        end
    endtask
    function automatic logic [31:0] vec();
        return {22'h0, steer.analog_loop, steer.remote_loop, steer.digital_loop, steer.rx_src,
            steer.tx_src, steer.rx_ais_inhibit, steer.tx_ais_inhibit, steer.tx_pattern_inhibit};
    endfunction
    function automatic logic [3:0] vec2();
        return {steer.ignore_tx_clock, steer.tx_det_on_system, steer.los_on_line,
            steer.rx_det_on_looped};
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    logic [3:0] modes [4] = '{4'h7, 4'h2, 4'h4, 4'h6};
    logic [3:0] msk [4] = '{4'h6, 4'he, 4'h7, 4'hf};
    logic [9:0] exps [4];
    logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    localparam logic [1:0] P = llc_pkg::SRC_PATTERN;
    localparam logic [1:0] L = llc_pkg::SRC_LOOPED;
    localparam logic [1:0] OK = llc_pkg::RESP_OKAY;
    localparam logic [1:0] SE = llc_pkg::RESP_SLVERR;
    initial begin
        exps = '{{3'b100, P, P, 3'b110}, {3'b010, P, P, 3'b010},
            {3'b001, P, P, 3'b100}, {3'b011, P, L, 3'b110}};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(offs[i], 32'h0, OK);
        rd(8'h14, 32'h0, SE);
        wr(8'h14, 32'h1, SE);
        wr(8'h08, 32'h80, OK);
        rd(8'h08, 32'h0, OK);
        cmp_data(vec(), {22'h0, 3'b000, P, P, 3'b000});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, {28'h0, modes[i]}, OK);
            rd(8'h00, {28'h0, modes[i]}, OK);
            @(negedge aclk);
            cmp_data(vec(), {22'h0, exps[i]});
            cmp_data({28'h0, vec2()}, {28'h0, msk[i]});
        end
        $display("test manual done");
        wr(8'h00, 32'h0, OK);
        wr(8'h04, 32'h0, OK);
        wr(8'h00, 32'h8, OK);
        mode <= 2'h1;
        repeat (12) @(posedge aclk);
        mode <= 2'h0;
        @(posedge aclk);
        mode <= 2'h1;
        repeat (12) @(posedge aclk);
        rd(8'h08, 32'h0, OK);
        repeat (HOLD) @(posedge aclk);
        rd(8'h08, 32'h80, OK);
        cmp_data(vec() & 32'h380, 32'h100);
        mode <= 2'h2;
        repeat (HOLD + 5) @(posedge aclk);
        rd(8'h08, 32'h0, OK);
        mode <= 2'h1;
        repeat (HOLD + 5) @(posedge aclk);
        wr(8'h00, 32'h0, OK);
        rd(8'h08, 32'h0, OK);
        cmp_data(vec() & 32'h380, 32'h0);
        mode <= 2'h0;
        wr(8'h04, 32'h8, OK);
        wr(8'h00, 32'ha, OK);
        mode <= 2'h1;
        repeat (HOLD + 5) @(posedge aclk);
        rd(8'h08, 32'h80, OK);
        cmp_data(vec() & 32'h18f, 32'h18f);
        mode <= 2'h2;
        repeat (HOLD + 5) @(posedge aclk);
        cmp_data(vec() & 32'h080, 32'h0);
        wr(8'h00, 32'h0, OK);
        wr(8'h04, 32'h0, OK);
        wr(8'h00, 32'hc, OK);
        mode <= 2'h1;
        repeat (HOLD + 5) @(posedge aclk);
        rd(8'h08, 32'h0, OK);
        cmp_data(vec() & 32'h380, 32'h080);
        mode <= 2'h0;
        $display("test auto done");
        wr(8'h00, 32'h0, OK);
        wr(8'h0c, 32'h13, OK);
        wr(8'h10, 32'h5, OK);
        @(negedge aclk);
        cmp_data({31'h0, mact}, 32'h1);
        cmp_data({29'h0, term}, 32'h7);
        cmp_data({30'h0, c0_in}, {30'h0, txt[7:6]});
        wr(8'h0c, 32'h03, OK);
        @(negedge aclk);
        cmp_data({30'h0, c0_in}, {30'h0, rxt[7:6]});
        wr(8'h00, 32'h2, OK);
        @(negedge aclk);
        cmp_data(vec() & 32'h380, 32'h100);
        wr(8'h0c, 32'h0, OK);
        @(negedge aclk);
        cmp_data({28'h0, mact, term}, 32'h5);
        cmp_data({30'h0, c0_in}, {30'h0, lp});
        $display("test monitor done");
        test_done();
    end
endmodule // tb_top
`default_nettype wire
